// ### include/sar_seq_map.svh
// constants and timing counts for the conversion sequencer
// Summary of operation
// - strobe rise after acquisition starts conversion
// - sampling switches open before other switching
// - then arrays leave inputs, go to ground
// - eighteen trials, MSB first, one element each
// - finish: acquisition, present code, signal done
// - trials paced by internal clock, no serial clock
// - result belongs to same edge, no pipeline
// - back-to-back conversions sustained
// - code is 18-bit two's complement
// - positive overrange saturates at 0x1ffff
// - negative overrange saturates at 0x20000
`ifndef SAR_SEQ_MAP_SVH
`define SAR_SEQ_MAP_SVH

`define SAR_RES_BITS        18
`define SAR_MSB_IDX         5'h11
`define SAR_CLK_PERIOD_NS   100
`define SAR_SETTLE_NS       300
`define SAR_ACQ_NS          200
`define SAR_SETTLE_CYC      ((`SAR_SETTLE_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_ACQ_CYC         ((`SAR_ACQ_NS + `SAR_CLK_PERIOD_NS - 1) / `SAR_CLK_PERIOD_NS)
`define SAR_DAC_RST         18'h00000
`define SAR_RESULT_RST      18'h00000
`define SAR_SIGN_FLIP       18'h20000

`endif

// ### include/sar_seq_pkg.sv
// types for the conversion sequencer
`default_nettype none
package sar_seq_pkg;

    typedef enum logic [2:0] {
        ST_ACQ,
        ST_OPEN_SW,
        ST_TO_GND,
        ST_TRIAL,
        ST_DECIDE
    } seq_state_e;

    typedef struct packed {
        seq_state_e  state;
        logic [4:0]  bit_idx;
        logic [3:0]  wait_cnt;
        logic [3:0]  acq_cnt;
        logic [17:0] dac;
        logic [17:0] result;
        logic        done;
        logic        strobe_meta;
        logic        strobe_sync;
        logic        strobe_prev;
        logic        comp_meta;
        logic        comp_sync;
    } seq_s;

endpackage

`default_nettype wire

// ### rtl/sar_conversion_sequencer.sv
// successive-approximation conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "sar_seq_map.svh"

module sar_conversion_sequencer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        arst_n_i,
    // host side
    input  wire logic        convert_strobe_i,
    // analog front end
    input  wire logic        comparator_i,
    output logic             sampling_switch_pos_o,
    output logic             sampling_switch_neg_o,
    output logic             array_to_input_o,
    output logic [17:0]      dac_bits_o,
    // result
    output logic [17:0]      result_o,
    output logic             busy_o,
    output logic             done_o
);

    localparam logic [3:0] SETTLE_CYC = 4'(`SAR_SETTLE_CYC);
    localparam logic [3:0] ACQ_CYC    = 4'(`SAR_ACQ_CYC);

    sar_seq_pkg::seq_s s_q;
    sar_seq_pkg::seq_s s_d;

    logic strobe_rise;
    logic acq_ready;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // both pin inputs pass two flops before use
        s_d.strobe_meta = convert_strobe_i;
        s_d.strobe_sync = s_q.strobe_meta;
        s_d.strobe_prev = s_q.strobe_sync;
        s_d.comp_meta   = comparator_i;
        s_d.comp_sync   = s_q.comp_meta;
        strobe_rise = s_q.strobe_sync & ~s_q.strobe_prev;
        acq_ready   = (s_q.acq_cnt == ACQ_CYC);
        unique case (s_q.state)
            sar_seq_pkg::ST_ACQ: begin
                if (!acq_ready) begin
                    s_d.acq_cnt = s_q.acq_cnt + 4'h1;
                end
                // early edges are dropped: tracking not yet settled
                if (strobe_rise && acq_ready) begin
                    s_d.state   = sar_seq_pkg::ST_OPEN_SW;
                    s_d.acq_cnt = 4'h0;
                end
            end
            sar_seq_pkg::ST_OPEN_SW: begin
                // switches open alone for one cycle
                s_d.state = sar_seq_pkg::ST_TO_GND;
            end
            sar_seq_pkg::ST_TO_GND: begin
                // arrays now grounded, held sample on comparator
                s_d.state    = sar_seq_pkg::ST_TRIAL;
                s_d.bit_idx  = `SAR_MSB_IDX;
                s_d.dac      = `SAR_DAC_RST;
                s_d.dac[17]  = 1'b1;
                s_d.wait_cnt = 4'h0;
            end
            sar_seq_pkg::ST_TRIAL: begin
                // wait covers dac settling plus comparator sync
                if (s_q.wait_cnt == SETTLE_CYC) begin
                    s_d.state = sar_seq_pkg::ST_DECIDE;
                end else begin
                    s_d.wait_cnt = s_q.wait_cnt + 4'h1;
                end
            end
            sar_seq_pkg::ST_DECIDE: begin
                s_d.dac[s_q.bit_idx] = s_q.comp_sync;
                s_d.wait_cnt = 4'h0;
                if (s_q.bit_idx == 5'h00) begin
                    // offset binary to two's complement; all-ones and
                    // all-zeros trials give the saturated end codes
                    s_d.result = {s_q.dac[17:1], s_q.comp_sync} ^ `SAR_SIGN_FLIP;
                    s_d.done   = 1'b1;
                    s_d.state  = sar_seq_pkg::ST_ACQ;
                end else begin
                    s_d.bit_idx = s_q.bit_idx - 5'h01;
                    s_d.dac[s_q.bit_idx - 5'h01] = 1'b1;
                    s_d.state = sar_seq_pkg::ST_TRIAL;
                end
            end
            default: begin
                // unused state codes fall back to acquisition
                s_d.state = sar_seq_pkg::ST_ACQ;
            end
        endcase
        // strobe level is not looked at outside acquisition
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_q.state       <= sar_seq_pkg::ST_ACQ;
            s_q.bit_idx     <= 5'h00;
            s_q.wait_cnt    <= 4'h0;
            s_q.acq_cnt     <= 4'h0;
            s_q.dac         <= `SAR_DAC_RST;
            s_q.result      <= `SAR_RESULT_RST;
            s_q.done        <= 1'b0;
            s_q.strobe_meta <= 1'b0;
            s_q.strobe_sync <= 1'b0;
            s_q.strobe_prev <= 1'b0;
            s_q.comp_meta   <= 1'b0;
            s_q.comp_sync   <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sampling_switch_pos_o = (s_q.state == sar_seq_pkg::ST_ACQ);
    assign sampling_switch_neg_o = (s_q.state == sar_seq_pkg::ST_ACQ);
    assign array_to_input_o      = (s_q.state == sar_seq_pkg::ST_ACQ) ||
                                   (s_q.state == sar_seq_pkg::ST_OPEN_SW);
    assign dac_bits_o            = s_q.dac;
    assign result_o              = s_q.result;
    assign busy_o                = (s_q.state != sar_seq_pkg::ST_ACQ);
    assign done_o                = s_q.done;

endmodule // sar_conversion_sequencer

`default_nettype wire

// ### test/sar_seq_monitor.sv
// assertions on the conversion sequencer ports
`timescale 1ns/1ps
`default_nettype none
module sar_seq_monitor (
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    input wire logic        convert_strobe_i,
    input wire logic        sampling_switch_pos_o,
    input wire logic        sampling_switch_neg_o,
    input wire logic        array_to_input_o,
    input wire logic [17:0] dac_bits_o,
    input wire logic [17:0] result_o,
    input wire logic        busy_o,
    input wire logic        done_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    chk_start_edge: assert property ($rose(busy_o) |-> $past(convert_strobe_i, 3) && !$past(convert_strobe_i, 4))
        else $error("conversion start without strobe rise");
    chk_open_first: assert property ($rose(busy_o) |-> !sampling_switch_pos_o && !sampling_switch_neg_o && array_to_input_o)
        else $error("switches not opened first");
    chk_ground_next: assert property ($rose(busy_o) |=> !array_to_input_o ##1 dac_bits_o == 18'h20000)
        else $error("arrays not grounded before msb trial");
    chk_switch_busy: assert property (busy_o |-> !sampling_switch_pos_o && !sampling_switch_neg_o)
        else $error("switch closed during conversion");
    chk_done_time: assert property ($rose(busy_o) |-> ##92 done_o)
        else $error("done not at expected cycle");
    chk_done_pulse: assert property (done_o |=> !done_o)
        else $error("done longer than one cycle");
    chk_result_hold: assert property (!done_o |-> $stable(result_o))
        else $error("result changed without done");
    chk_code_map: assert property (done_o |-> result_o == (dac_bits_o ^ 18'h20000))
        else $error("result not two's complement of trials");
    chk_no_abort: assert property ($fell(busy_o) |-> done_o)
        else $error("conversion ended without done");
    cover property ($rose(busy_o));
    cover property (done_o && result_o == 18'h1ffff);
    cover property (done_o && result_o == 18'h20000);
endmodule // sar_seq_monitor
bind sar_conversion_sequencer sar_seq_monitor u_mon (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .convert_strobe_i(convert_strobe_i), .sampling_switch_pos_o(sampling_switch_pos_o),
    .sampling_switch_neg_o(sampling_switch_neg_o), .array_to_input_o(array_to_input_o),
    .dac_bits_o(dac_bits_o), .result_o(result_o), .busy_o(busy_o), .done_o(done_o));
`default_nettype wire

// ### test/sar_frontend_model.sv
// comparator and sampled input of the capacitive array
`timescale 1ns/1ps
`default_nettype none
module sar_frontend_model (
    input wire logic               switch_closed_i,
    input wire logic [17:0]        dac_bits_i,
    input wire logic signed [19:0] level_i,
    output logic                   comparator_o
);
    logic signed [19:0] held = 20'sh00000;
    // frozen at switch opening, later input moves are not seen
    always @(negedge switch_closed_i) held = level_i;
    // out of range levels pin the comparator, giving saturation
    assign comparator_o = held >= $signed({2'b00, dac_bits_i});
endmodule // sar_frontend_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 0, arst_n_i = 0, convert_strobe_i = 0, comparator_i, sw_pos, sw_neg, to_in, busy_o, done_o;
    logic [17:0] dac, result_o;
    logic signed [19:0] level = 20'sh00000;
    int n_mismatch = 0, n_compared = 0;
    initial forever #50 clk_i = ~clk_i;
    sar_conversion_sequencer DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .convert_strobe_i(convert_strobe_i),
        .comparator_i(comparator_i), .sampling_switch_pos_o(sw_pos), .sampling_switch_neg_o(sw_neg),
        .array_to_input_o(to_in), .dac_bits_o(dac), .result_o(result_o), .busy_o(busy_o), .done_o(done_o));
    sar_frontend_model u_fe (.switch_closed_i(sw_pos), .dac_bits_i(dac), .level_i(level), .comparator_o(comparator_i));
    task end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task check(input string name, input logic [17:0] exp, input logic [17:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #5;
    endtask
    task wait_done(input logic [17:0] exp);
        int i;
        for (i = 0; i < 200 && done_o !== 1'b1; i++) step(1);
        if (i == 200) begin
            n_mismatch++;
            end_of_test();
        end else begin
            check("result", exp, result_o);
        end
    endtask
    // strobe dropped early: the conversion must still finish
    task convert(input logic signed [19:0] lv, input logic [17:0] exp);
        level = lv;
        convert_strobe_i = 1;
        step(6);
        convert_strobe_i = 0;
        wait_done(exp);
    endtask
    task t_codes;
        logic signed [19:0] lv [7] = '{20'sh20000, 20'sh20001, 20'sh1ffff, 20'sh3ffff, 20'sh40010, -20'sd5, 20'sh00001};
        logic [17:0] ex [7] = '{18'h00000, 18'h00001, 18'h3ffff, 18'h1ffff, 18'h1ffff, 18'h20000, 18'h20001};
        foreach (lv[k]) convert(lv[k], ex[k]);
    endtask
    // a strobe rise during busy is ignored, next one follows at once
    task t_back;
        level = 20'sh2abcd;
        convert_strobe_i = 1;
        step(6);
        convert_strobe_i = 0;
        step(20);
        convert_strobe_i = 1;
        step(3);
        convert_strobe_i = 0;
        wait_done(18'h0abcd);
        check("dac", 18'h2abcd, dac);
        check("switches", 18'h00007, {15'h0000, sw_pos, sw_neg, to_in});
        step(4);
        check("busy", 18'h00000, {17'h00000, busy_o});
        convert(20'sh15555, 18'h35555);
    endtask
    // reset in mid-conversion, then a clean conversion
    task t_reset;
        level = 20'sh30000;
        convert_strobe_i = 1;
        step(20);
        arst_n_i = 0;
        convert_strobe_i = 0;
        step(2);
        check("reset result", 18'h00000, result_o);
        check("reset busy", 18'h00000, {17'h00000, busy_o});
        arst_n_i = 1;
        step(3);
        convert(20'sh30000, 18'h10000);
    endtask
    initial begin
        step(12);
        arst_n_i = 1;
        step(3);
        t_codes();
        t_back();
        t_reset();
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
